/* File: dv/dtmf_transceiver_host_and_steering_bench.sv */
// Self-checking bench for the tone transceiver host port.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module dtmf_transceiver_host_and_steering_bench
   import tone_xcvr_pkg::*;
;
   logic        clk, rstn, strobe_mode, tone_pair_valid, steering_input, call_progress_level, bus_oe_n;
   logic        irq_oe_n, o0, tone_on, gt_oe_n;
   logic [3:0]  tone_pair_code, bus_out, tx_code, rd;
   host_bus_s   host;
   wire  [3:0]  nibble;
   int          err_count, num_checks;
   int unsigned code;
   logic [3:0]  expq[$];
   assign nibble = bus_oe_n ? 4'hz : bus_out;
   tone_xcvr_host u_dut (
      .clk(clk), .rstn(rstn), .host(host), .strobe_mode(strobe_mode),
      .host_nibble_bus_out(bus_out), .host_nibble_bus_oe_n(bus_oe_n),
      .tone_pair_valid(tone_pair_valid), .tone_pair_code(tone_pair_code),
      .call_progress_level(call_progress_level), .early_tone_detect(),
      .steering_input(steering_input), .guard_time_out(), .guard_time_oe_n(gt_oe_n),
      .interrupt_or_tone_activity_out(), .interrupt_or_tone_activity_oe_n(irq_oe_n),
      .tx_code(tx_code), .tx_tone_on(tone_on)
   );
   tone_host_model u_host (.clk(clk), .strobe_mode(strobe_mode), .rd_data(nibble), .host(host));
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results;
      if (err_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      strobe_mode = 1'b1;
      tone_pair_valid = 1'b0;
      tone_pair_code = 4'h0;
      steering_input = 1'b0;
      call_progress_level = 1'b0;
      err_count = 0;
      num_checks = 0;
      void'($urandom(32'hd2ba_aacb));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      u_host.access(1'b0, REG_DATA, 4'h0, rd);
      chk(rd, RX_RESET);
      for (int m = 1; m >= 0; m--) begin
         strobe_mode <= m[0];
         u_host.access(1'b1, REG_CTRL, 4'h1, rd);
         for (int i = 0; i < 3; i++) begin
            code = $urandom;
            @(posedge clk);
            tone_pair_valid <= 1'b1;
            tone_pair_code <= code[3:0];
            @(posedge clk);
            tone_pair_valid <= 1'b0;
            @(posedge clk);
            tone_pair_valid <= 1'b1;
            @(posedge clk);
            steering_input <= 1'b1;
            expq.push_back(code[3:0]);
            for (int w = 0; w < 40 && irq_oe_n !== 1'b0; w++) @(posedge clk);
            chk({3'b000, irq_oe_n}, 4'h0);
            if (irq_oe_n !== 1'b0) results();
            u_host.access(1'b0, REG_CTRL, 4'h0, rd);
            chk(rd & 4'hd, 4'h5);
            u_host.access(1'b0, REG_DATA, 4'h0, rd);
            chk(rd, expq.pop_front());
            tone_pair_valid <= 1'b0;
            steering_input <= 1'b0;
         end
         code = $urandom;
         u_host.access(1'b1, REG_DATA, code[3:0], rd);
         @(posedge clk);
         chk(tx_code, code[3:0]);
      end
      u_host.access(1'b1, REG_CTRL, 4'h2, rd);
      repeat (4) @(posedge clk);
      o0 = irq_oe_n;
      call_progress_level <= 1'b1;
      repeat (4) @(posedge clk);
      chk({3'b000, irq_oe_n ^ o0}, 4'h1);
      u_host.access(1'b1, REG_CTRL, 4'h8, rd);
      @(posedge clk);
      chk({3'b000, tone_on}, 4'h1);
      chk({3'b000, gt_oe_n}, 4'h0);
      u_host.access(1'b1, REG_CTRL, 4'hc, rd);
      @(posedge clk);
      chk({3'b000, tone_on}, 4'h0);
      code = $urandom;
      u_host.access(1'b1, REG_DATA, code[3:0], rd);
      repeat (2) @(posedge clk);
      chk({3'b000, tone_on}, 4'h1);
      u_host.access(1'b0, REG_CTRL, 4'h0, rd);
      chk(rd & 4'h2, 4'h0);
      results();
   end
endmodule : dtmf_transceiver_host_and_steering_bench

/* File: dv/tone_host_model.sv */
// Host controller model on the 4-bit parallel bus.
// Assumes accesses are started by hierarchical task calls.
`timescale 1ns/1ps
module tone_host_model
   import tone_xcvr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       strobe_mode,
   input  wire logic [3:0] rd_data,
   output host_bus_s       host
);
   initial host = '{1'b1, 1'b1, 1'b0, 1'b0, 4'h0};
   // One access held two edges, released at the sampling edge
   task automatic access(input logic wr, input logic rs, input logic [3:0] din, output logic [3:0] dout);
      @(posedge clk);
      host.chip_select_n <= 1'b0;
      host.register_select <= rs;
      host.direction <= !wr;
      host.data_strobe_in <= strobe_mode | wr;
      host.host_nibble_bus_in <= din;
      repeat (2) @(posedge clk);
      dout = rd_data;
      host.chip_select_n <= 1'b1;
      host.data_strobe_in <= !strobe_mode;
      host.host_nibble_bus_in <= ~din;
      @(posedge clk);
   endtask : access
endmodule : tone_host_model

/* File: dv/tone_xcvr_checker.sv */
// Port-level assertions for the tone transceiver host port.
// Assumes host pins and detector flags are synchronous to clk.
`timescale 1ns/1ps
module tone_xcvr_checker
   import tone_xcvr_pkg::*;
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire host_bus_s  host,
   input wire logic       strobe_mode,
   input wire logic [3:0] host_nibble_bus_out,
   input wire logic       host_nibble_bus_oe_n,
   input wire logic       tone_pair_valid,
   input wire logic [3:0] tone_pair_code,
   input wire logic       early_tone_detect,
   input wire logic       steering_input,
   input wire logic       guard_time_out,
   input wire logic       interrupt_or_tone_activity_out
);
   logic       steer_q;
   logic [3:0] rx_copy;
   logic       rd_qual;
   assign rd_qual = !host.chip_select_n && (strobe_mode ? host.direction && host.data_strobe_in
                                                        : host.direction && !host.data_strobe_in);
   // Code expected in the receive latch
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         steer_q <= 1'b0;
         rx_copy <= RX_RESET;
      end else begin
         steer_q <= steering_input;
         if (steering_input && !steer_q) rx_copy <= tone_pair_code;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   a_bus_float: assert property (!host_nibble_bus_oe_n |->
      !host.chip_select_n && strobe_mode == host.data_strobe_in) else $error("bus driven while floating");
   a_dir_read: assert property (strobe_mode && !host_nibble_bus_oe_n |-> host.direction)
      else $error("bus driven in a strobe write");
   a_read_drive: assert property (rd_qual |-> !host_nibble_bus_oe_n)
      else $error("bus not driven in a read");
   a_early_follow: assert property (early_tone_detect == tone_pair_valid)
      else $error("early detect off the tone flag");
   a_guard_level: assert property (1'b1 |=> guard_time_out ==
      ($past(tone_pair_valid) && $past(steering_input))) else $error("guard level wrong");
   a_irq_drain: assert property (interrupt_or_tone_activity_out == 1'b0)
      else $error("open drain pin driven high");
   a_read_data: assert property (rd_qual && $past(rd_qual) && !host.register_select
      && $stable(host.register_select) |-> host_nibble_bus_out == rx_copy) else $error("receive code wrong");
   a_status_top: assert property (rd_qual && $past(rd_qual) && host.register_select
      && $stable(host.register_select) |-> !host_nibble_bus_out[3]) else $error("status top bit set");
endmodule : tone_xcvr_checker

bind tone_xcvr_host tone_xcvr_checker u_chk (
   .clk(clk), .rstn(rstn), .host(host), .strobe_mode(strobe_mode),
   .host_nibble_bus_out(host_nibble_bus_out), .host_nibble_bus_oe_n(host_nibble_bus_oe_n),
   .tone_pair_valid(tone_pair_valid), .tone_pair_code(tone_pair_code),
   .early_tone_detect(early_tone_detect), .steering_input(steering_input),
   .guard_time_out(guard_time_out), .interrupt_or_tone_activity_out(interrupt_or_tone_activity_out)
);

/* File: hdl/tone_xcvr_host.sv */
// Host port, steering, interrupt pin and burst timer of the tone transceiver.
// Assumes host pins and detector flags are synchronous to clk.
`timescale 1ns/1ps
module tone_xcvr_host
   import tone_xcvr_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rstn,
   input  wire host_bus_s host,
   input  wire logic      strobe_mode,
   output logic [3:0]     host_nibble_bus_out,
   output logic           host_nibble_bus_oe_n,
   input  wire logic      tone_pair_valid,
   input  wire logic [3:0] tone_pair_code,
   input  wire logic      call_progress_level,
   output logic           early_tone_detect,
   input  wire logic      steering_input,
   output logic           guard_time_out,
   output logic           guard_time_oe_n,
   output logic           interrupt_or_tone_activity_out,
   output logic           interrupt_or_tone_activity_oe_n,
   output logic [3:0]     tx_code,
   output logic           tx_tone_on
);

   // ***********************************************
   // Bus decode
   // ***********************************************
   logic read_q;
   logic write_q;
   logic write_q_d;
   logic [3:0] wr_data_d;
   logic       wr_sel_d;
   logic [3:0] rx_data;
   logic [3:0] ctrl;
   logic       irq_flag;
   logic       dsteer;
   logic       tx_ready;
   logic       osc_tick;

   always_comb begin
      // direction pin meaning depends on bus style
      if (strobe_mode) begin
         read_q  = !host.chip_select_n && host.data_strobe_in && host.direction;
         write_q = !host.chip_select_n && host.data_strobe_in && !host.direction;
      end else begin
         read_q  = !host.chip_select_n && !host.data_strobe_in;
         write_q = !host.chip_select_n && !host.direction;
      end
   end

   // Status nibble assembled from its field positions
   function automatic logic [3:0] status_word(input logic irq, input logic ready, input logic steer);
      logic [3:0] w;
      w              = 4'h0;
      w[STAT_IRQ]    = irq;
      w[STAT_TX_RDY] = ready;
      w[STAT_DSTEER] = steer;
      return w;
   endfunction : status_word

   // Read data registered, enable combinational
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_nibble_bus_out <= 4'h0;
      end else if (host.register_select == REG_DATA) begin
         host_nibble_bus_out <= rx_data;
      end else begin
         host_nibble_bus_out <= status_word(irq_flag, tx_ready, dsteer);
      end
   end

   assign host_nibble_bus_oe_n = !read_q;

   // Write level one cycle late, for the end-of-write edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         write_q_d <= 1'b0;
      end else begin
         write_q_d <= write_q;
      end
   end

   // Write data and select, resampled through the whole write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_data_d <= 4'h0;
         wr_sel_d  <= 1'b0;
      end else if (write_q) begin
         wr_data_d <= host.host_nibble_bus_in;
         wr_sel_d  <= host.register_select;
      end
   end

   logic wr_end;
   assign wr_end = write_q_d && !write_q;

   // ***********************************************
   // Control and transmit registers
   // ***********************************************
   logic tx_load;
   logic ctrl_wr;
   logic data_wr;
   assign ctrl_wr = wr_end && (wr_sel_d == REG_CTRL);
   assign data_wr = wr_end && (wr_sel_d == REG_DATA);

   // Control bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl <= wr_data_d;
      end
   end

   // Transmit code
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_code <= 4'h0;
      end else if (data_wr) begin
         tx_code <= wr_data_d;
      end
   end

   // One-cycle load strobe for the burst timer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_load <= 1'b0;
      end else begin
         tx_load <= data_wr;
      end
   end

   // ***********************************************
   // Oscillator tick
   // ***********************************************
   logic [7:0] osc_cnt;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         osc_cnt <= 8'h00;
      end else if (osc_cnt == 8'(OSC_DIV - 1)) begin
         osc_cnt <= 8'h00;
      end else begin
         osc_cnt <= osc_cnt + 8'h01;
      end
   end
   assign osc_tick = (osc_cnt == 8'(OSC_DIV - 1));

   // ***********************************************
   // Burst timer
   // ***********************************************
   tx_state_e tx_state;
   logic [17:0] burst_cnt;
   logic        tx_done;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_state  <= TX_IDLE;
         burst_cnt <= 18'h0_0000;
         tx_done   <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         case (tx_state)
            TX_IDLE: begin
               if (tx_load && ctrl[CTRL_TX_EN] && ctrl[CTRL_BURST_EN]) begin
                  tx_state  <= TX_BURST;
                  burst_cnt <= 18'(BURST_CNT - 1);
               end
            end
            TX_BURST: begin
               if (osc_tick) begin
                  if (burst_cnt == 18'h0_0000) begin
                     tx_state  <= TX_PAUSE;
                     burst_cnt <= 18'(PAUSE_CNT - 1);
                     tx_done   <= 1'b1;
                  end else begin
                     burst_cnt <= burst_cnt - 18'h0_0001;
                  end
               end
            end
            TX_PAUSE: begin
               if (osc_tick) begin
                  if (burst_cnt == 18'h0_0000) begin
                     tx_state <= TX_IDLE;
                  end else begin
                     burst_cnt <= burst_cnt - 18'h0_0001;
                  end
               end
            end
            default: begin
               tx_state <= TX_IDLE;
            end
         endcase
      end
   end

   assign tx_ready   = (tx_state == TX_IDLE);
   assign tx_tone_on = (tx_state == TX_BURST) || (ctrl[CTRL_TX_EN] && !ctrl[CTRL_BURST_EN]);

   // ***********************************************
   // Steering
   // ***********************************************
   assign early_tone_detect = tone_pair_valid;

   logic       registered;
   logic [7:0] settle_cnt;
   logic       take_pair;
   assign take_pair = steering_input && !registered;

   // Pair held until steering falls below threshold
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         registered <= 1'b0;
      end else if (take_pair) begin
         registered <= 1'b1;
      end else if (!steering_input) begin
         registered <= 1'b0;
      end
   end

   // Receive latch
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_data <= RX_RESET;
      end else if (take_pair) begin
         rx_data <= tone_pair_code;
      end
   end

   // Settling delay before the delayed steering flag
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         settle_cnt <= 8'h00;
      end else if (take_pair) begin
         settle_cnt <= 8'(SETTLE_CYC);
      end else if (registered && steering_input && settle_cnt != 8'h00) begin
         settle_cnt <= settle_cnt - 8'h01;
      end
   end

   // Delayed steering flag
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dsteer <= 1'b0;
      end else if (!steering_input) begin
         dsteer <= 1'b0;
      end else if (registered && settle_cnt == 8'h00) begin
         dsteer <= 1'b1;
      end
   end

   // Drive high while detect and steering are both high, else low to reset the RC
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         guard_time_out <= 1'b0;
      end else begin
         guard_time_out <= tone_pair_valid && steering_input;
      end
   end
   assign guard_time_oe_n = 1'b0;

   // ***********************************************
   // Interrupt pin
   // ***********************************************
   logic dsteer_d;
   logic status_read_end;
   logic read_d;
   logic dsteer_rise;

   // Delayed steering one cycle late, for its rising edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dsteer_d <= 1'b0;
      end else begin
         dsteer_d <= dsteer;
      end
   end
   assign dsteer_rise = dsteer && !dsteer_d;

   // Read level one cycle late, for the end-of-read edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         read_d <= 1'b0;
      end else begin
         read_d <= read_q;
      end
   end
   assign status_read_end = read_d && !read_q && host.register_select == REG_CTRL;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_flag <= 1'b0;
      end else if (dsteer_rise || tx_done) begin
         irq_flag <= 1'b1;
      end else if (status_read_end) begin
         irq_flag <= 1'b0;
      end
   end

   assign interrupt_or_tone_activity_out = 1'b0;
   always_comb begin
      if (ctrl[CTRL_CP_MODE]) begin
         interrupt_or_tone_activity_oe_n = call_progress_level;
      end else if (ctrl[CTRL_IRQ_EN]) begin
         interrupt_or_tone_activity_oe_n = !(irq_flag || dsteer);
      end else begin
         interrupt_or_tone_activity_oe_n = 1'b1;
      end
   end

endmodule : tone_xcvr_host

/* File: hdl/tone_xcvr_pkg.sv */
// Constants and carrier types for the tone transceiver host port.
// Assumes a 200 MHz system clock and host pins synchronous to it.
//
// Summary of operation
// - Data lines float when chip select is high, strobe is low in strobe mode, or read is high in read/write mode.
// - The direction pin is read/not-write in strobe mode and an active-low write in read/write mode.
// - One register select pin chooses the addressed register on each access.
// - In interrupt mode the interrupt pin pulls low once a tone burst is sent or received.
// - In call progress mode the interrupt pin follows the band-filtered input as a square wave.
// - Early tone detect goes high as soon as a valid tone pair is recognised.
// - Early tone detect drops on any loss of the signal condition, however brief.
// - A steering input above threshold registers the detected pair into the output latch.
// - A steering input below threshold frees the device to take a new pair.
// - Guard time output resets the steering time constant from early detect and the steering level.
// - A burst counter times transmitted tone bursts and pauses in burst mode.
// - Internal timing derives from a 3.579545 MHz oscillator clock; the code ticks every 55 cycles of the 200 MHz clock instead.
// - A registered pair's 4-bit code is latched into receive data and read by the host.
// - In interrupt mode the interrupt pin is held low while the delayed steering flag is set.
package tone_xcvr_pkg;

   localparam int unsigned CLK_HZ         = 200_000_000;
   localparam int unsigned OSC_MILLIHZ    = 3_579_545_000;
   // System cycles per oscillator tick, rounded down (55)
   localparam int unsigned OSC_DIV        = int'((64'(CLK_HZ) * 64'd1000) / 64'(OSC_MILLIHZ));
   localparam int unsigned SETTLE_NS      = 50;
   localparam int unsigned SETTLE_CYC     = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned BURST_TICKS    = 50;  // Unused; oscillator ticks per ms are TICKS_PER_MS below
   localparam int unsigned BURST_MS       = 51;
   localparam int unsigned PAUSE_MS       = 51;
   localparam int unsigned TICKS_PER_MS   = 3580;
   localparam int unsigned BURST_CNT      = BURST_MS * TICKS_PER_MS;
   localparam int unsigned PAUSE_CNT      = PAUSE_MS * TICKS_PER_MS;

   localparam logic       REG_DATA        = 1'b0;
   localparam logic       REG_CTRL        = 1'b1;
   localparam logic [3:0] RX_RESET        = 4'h0;
   localparam logic [3:0] CTRL_RESET      = 4'h0;
   localparam int unsigned CTRL_IRQ_EN    = 0;
   localparam int unsigned CTRL_CP_MODE   = 1;
   localparam int unsigned CTRL_BURST_EN  = 2;
   localparam int unsigned CTRL_TX_EN     = 3;
   localparam int unsigned STAT_IRQ       = 0;
   localparam int unsigned STAT_TX_RDY    = 1;
   localparam int unsigned STAT_DSTEER    = 2;

   typedef struct packed {
      logic       chip_select_n;
      logic       direction;
      logic       data_strobe_in;
      logic       register_select;
      logic [3:0] host_nibble_bus_in;
   } host_bus_s;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_BURST = 2'b01,
      TX_PAUSE = 2'b11
   } tx_state_e;

endpackage : tone_xcvr_pkg
